// File: logic/table_mem_map.svh
`ifndef TABLE_MEM_MAP_SVH
`define TABLE_MEM_MAP_SVH

// ==========================================================
// Program memory geometry
`define PROG_ADDR_W          11
`define PROG_WORD_W          16
`define PROG_HIGH_IMPL_W     8
`define RESET_VECTOR         11'h000

// ==========================================================
// Special register addresses
`define ADDR_IND0            8'h00
`define ADDR_MPTR0           8'h01
`define ADDR_IND1            8'h02
`define ADDR_MPTR1           8'h03
`define ADDR_BANK_PTR        8'h04
`define ADDR_TABLE_PTR_LOW   8'h07
`define ADDR_TABLE_HIGH      8'h08
`define ADDR_TABLE_PTR_HIGH  8'h09
`define ADDR_EEPROM_CTRL     8'h40

// ==========================================================
// General purpose RAM
`define GP_RAM_BASE          8'h80
`define GP_RAM_LAST          8'hff
`define GP_RAM_DEPTH         128
`define GP_RAM_AW            7

// ==========================================================
// Field positions and reset values
`define BANK_SEL_BIT         0
`define BANK_PTR_RST         8'h00
`define TABLE_PTR_RST        8'h00
`define TABLE_HIGH_RST       8'h00
`define EEPROM_CTRL_RST      8'h00

// ==========================================================
// Table instructions take two instruction cycles
`define TABLE_CYCLES         2

`endif

// File: logic/table_mem_pkg.sv
package table_mem_pkg;
	typedef enum logic [1:0]
	{
		op_none,
		op_table_read,
		op_table_read_last
	} table_op_t;

	typedef enum logic [1:0]
	{
		st_idle,
		st_fetch,
		st_finish
	} table_state_t;
endpackage

// File: logic/gp_ram.sv
`include "table_mem_map.svh"

module gp_ram
(
	input  wire logic                     clk,
	input  wire logic                     wr_en,
	input  wire logic [`GP_RAM_AW-1:0]    wr_addr,
	input  wire logic [7:0]               wr_data,
	input  wire logic [`GP_RAM_AW-1:0]    rd_addr,
	output logic      [7:0]               rd_data_ff
);
	// No reset on the array: the data memory is volatile
	logic [7:0] mem [0:`GP_RAM_DEPTH-1];

	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data_ff <= mem[rd_addr];
	end
endmodule

// File: logic/table_mem_core.sv
`include "table_mem_map.svh"

module table_mem_core
	import table_mem_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic                      prog_mode_select_n,
	input  wire logic                      prog_serial_data_in,
	input  wire logic                      prog_serial_clock,
	input  wire logic                      data_req,
	input  wire logic                      data_write,
	input  wire logic                      data_indirect,
	input  wire logic [7:0]                data_addr,
	input  wire logic [7:0]                data_wdata,
	input  wire logic                      table_req,
	input  wire logic                      table_last_page,
	input  wire logic [7:0]                table_dest,
	input  wire logic [`PROG_ADDR_W-1:0]   cur_pc,
	input  wire logic [`PROG_WORD_W-1:0]   prog_rdata,
	output logic      [7:0]                data_rdata_ff,
	output logic                           data_rvalid_ff,
	output logic      [`PROG_ADDR_W-1:0]   fetch_addr_ff,
	output logic                           fetch_restart_ff,
	output logic      [`PROG_ADDR_W-1:0]   prog_addr_ff,
	output logic                           prog_rd_ff,
	output logic                           core_stall_ff,
	output logic                           core_halt_ff,
	output logic                           table_done_ff,
	output logic      [7:0]                table_dest_ff,
	output logic      [7:0]                table_low_ff,
	output logic      [7:0]                table_high_latch_ff,
	output logic      [7:0]                bank_pointer_ff,
	output logic                           prog_serial_data_out_ff,
	output logic                           prog_serial_data_oe_ff,
	output logic                           prog_pins_owned_ff
);
	// ==========================================================
	// Register state
	table_state_t         state_ff;
	table_state_t         nxt_state;
	logic [7:0]           table_ptr_low_ff;
	logic [7:0]           table_ptr_high_ff;
	logic [7:0]           eeprom_ctrl_ff;
	logic [7:0]           hold_dest_ff;
	logic                 started_ff;
	logic [7:0]           ram_rdata;
	logic                 ram_sel_ff;
	logic [7:0]           reg_rdata_ff;

	// ==========================================================
	// Address decode
	wire       bank1       = bank_pointer_ff[`BANK_SEL_BIT];
	wire       eff_bank1   = data_indirect & bank1;
	wire       acc_ok      = data_req & prog_mode_select_n & (state_ff == st_idle);
	wire       hit_gp      = (data_addr >= `GP_RAM_BASE) & ~eff_bank1;
	wire       hit_bank    = data_addr == `ADDR_BANK_PTR;
	wire       hit_tpl     = data_addr == `ADDR_TABLE_PTR_LOW;
	wire       hit_tph     = data_addr == `ADDR_TABLE_PTR_HIGH;
	wire       hit_latch   = data_addr == `ADDR_TABLE_HIGH;
	wire       hit_eeprom  = (data_addr == `ADDR_EEPROM_CTRL) & eff_bank1;
	wire       hit_any     = hit_gp | hit_bank | hit_tpl | hit_tph | hit_latch | hit_eeprom;
	wire       wr          = acc_ok & data_write;
	wire       ram_we      = wr & hit_gp;
	wire [`GP_RAM_AW-1:0] ram_a = data_addr[`GP_RAM_AW-1:0];
	wire [7:0] reg_mux     = hit_bank   ? bank_pointer_ff :
	                         hit_tpl    ? table_ptr_low_ff :
	                         hit_tph    ? table_ptr_high_ff :
	                         hit_latch  ? table_high_latch_ff :
	                         hit_eeprom ? eeprom_ctrl_ff : 8'h00;

	// Page-relative read keeps the page bits of the running instruction
	wire [`PROG_ADDR_W-1:0] full_addr = {table_ptr_high_ff[`PROG_ADDR_W-9:0], table_ptr_low_ff};
	wire [`PROG_ADDR_W-1:0] page_addr = {cur_pc[`PROG_ADDR_W-1:8], table_ptr_low_ff};
	// Word bits beyond the implemented width must come back as zero
	wire [7:0] high_mask = 8'hff >> (8 - `PROG_HIGH_IMPL_W);
	wire table_go = table_req & prog_mode_select_n & (state_ff == st_idle);

	// ==========================================================
	// Table read sequencer
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			st_idle:   if (table_go) nxt_state = st_fetch;
			st_fetch:  nxt_state = st_finish;
			st_finish: nxt_state = st_idle;
			default:   nxt_state = st_idle;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			state_ff <= st_idle;
		else if (!prog_mode_select_n)
			state_ff <= st_idle;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prog_addr_ff  <= `RESET_VECTOR;
			prog_rd_ff    <= 1'b0;
			hold_dest_ff  <= 8'h00;
		end
		else
		begin
			prog_rd_ff <= table_go;
			if (table_go)
			begin
				prog_addr_ff <= table_last_page ? page_addr : full_addr;
				hold_dest_ff <= table_dest;
			end
		end
	end

	// Stall covers both instruction cycles of the table operation
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			core_stall_ff       <= 1'b0;
			table_done_ff       <= 1'b0;
			table_dest_ff       <= 8'h00;
			table_low_ff        <= 8'h00;
			table_high_latch_ff <= `TABLE_HIGH_RST;
		end
		else
		begin
			core_stall_ff <= table_go | (state_ff == st_fetch);
			table_done_ff <= state_ff == st_fetch;
			if (state_ff == st_fetch)
			begin
				table_dest_ff       <= hold_dest_ff;
				table_low_ff        <= prog_rdata[7:0];
				// Latch only changes here; bus writes to it are dropped
				table_high_latch_ff <= prog_rdata[15:8] & high_mask;
			end
		end
	end

	// ==========================================================
	// Software-visible registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bank_pointer_ff   <= `BANK_PTR_RST;
			table_ptr_low_ff  <= `TABLE_PTR_RST;
			table_ptr_high_ff <= `TABLE_PTR_RST;
			eeprom_ctrl_ff    <= `EEPROM_CTRL_RST;
		end
		else if (wr)
		begin
			if (hit_bank)
				bank_pointer_ff <= {7'h00, data_wdata[`BANK_SEL_BIT]};
			if (hit_tpl)
				table_ptr_low_ff <= data_wdata;
			if (hit_tph)
				table_ptr_high_ff <= data_wdata;
			if (hit_eeprom)
				eeprom_ctrl_ff <= data_wdata;
		end
	end

	gp_ram u_gp_ram
	(
		.clk        (clk),
		.wr_en      (ram_we),
		.wr_addr    (ram_a),
		.wr_data    (data_wdata),
		.rd_addr    (ram_a),
		.rd_data_ff (ram_rdata)
	);

	// Read data returns two cycles after the request: RAM register, then output
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ram_sel_ff     <= 1'b0;
			reg_rdata_ff   <= 8'h00;
			data_rvalid_ff <= 1'b0;
			data_rdata_ff  <= 8'h00;
			started_ff     <= 1'b0;
		end
		else
		begin
			ram_sel_ff     <= acc_ok & ~data_write & hit_gp;
			reg_rdata_ff   <= (acc_ok & ~data_write) ? reg_mux : 8'h00;
			data_rvalid_ff <= started_ff;
			started_ff     <= acc_ok & ~data_write;
			data_rdata_ff  <= ram_sel_ff ? ram_rdata : reg_rdata_ff;
		end
	end

	// ==========================================================
	// Reset vector and programming mode
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fetch_addr_ff           <= `RESET_VECTOR;
			fetch_restart_ff        <= 1'b1;
			core_halt_ff            <= 1'b0;
			prog_pins_owned_ff      <= 1'b0;
			prog_serial_data_out_ff <= 1'b0;
			prog_serial_data_oe_ff  <= 1'b0;
		end
		else
		begin
			fetch_addr_ff      <= `RESET_VECTOR;
			fetch_restart_ff   <= 1'b0;
			core_halt_ff       <= ~prog_mode_select_n;
			prog_pins_owned_ff <= ~prog_mode_select_n;
			// Device never drives the serial pins; programmer owns clock and data
			prog_serial_data_out_ff <= 1'b0;
			prog_serial_data_oe_ff  <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	chk_reset_vector: assert property (@(posedge clk) $rose(reset_n)
		|-> fetch_addr_ff == `RESET_VECTOR && fetch_restart_ff)
		else $error("fetch not at reset vector");

	sequence s_take;
		table_go;
	endsequence

	// Stall in both instruction cycles, done with the second, released after
	sequence s_two_cycle;
		(core_stall_ff && !table_done_ff) ##1 (core_stall_ff && table_done_ff) ##1 !core_stall_ff;
	endsequence

	chk_table_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		s_take |=> s_two_cycle)
		else $error("table read not two cycles");

	chk_table_addr: assert property (@(posedge clk) disable iff (!reset_n)
		table_go && !table_last_page |=> prog_addr_ff == $past(full_addr))
		else $error("table address wrong");

	chk_page_rel: assert property (@(posedge clk) disable iff (!reset_n)
		table_go && table_last_page
		|=> prog_addr_ff == {$past(cur_pc[10:8]), $past(table_ptr_low_ff)})
		else $error("page relative address wrong");

	chk_high_latch: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff == st_fetch |=> table_high_latch_ff == $past(prog_rdata[15:8])
		&& table_low_ff == $past(prog_rdata[7:0]))
		else $error("table bytes wrong");

	chk_latch_ro: assert property (@(posedge clk) disable iff (!reset_n)
		state_ff != st_fetch |=> $stable(table_high_latch_ff))
		else $error("latch changed without table read");

	chk_bank_clear: assert property (@(posedge clk) disable iff (!reset_n)
		bank_pointer_ff[7:1] == 7'h00)
		else $error("bank pointer upper bits set");

	// A direct read of the bank 1 control address must see nothing there
	chk_direct_bank0: assert property (@(posedge clk) disable iff (!reset_n)
		acc_ok && !data_write && !data_indirect && data_addr == `ADDR_EEPROM_CTRL
		|-> ##2 data_rvalid_ff && data_rdata_ff == 8'h00)
		else $error("direct access reached bank 1");

	chk_unused_zero: assert property (@(posedge clk) disable iff (!reset_n)
		acc_ok && !data_write && !hit_any |-> ##2 data_rvalid_ff && data_rdata_ff == 8'h00)
		else $error("unused location not zero");

	chk_prog_halt: assert property (@(posedge clk) disable iff (!reset_n)
		!prog_mode_select_n |=> core_halt_ff && state_ff == st_idle && !prog_serial_data_oe_ff)
		else $error("core not halted in programming mode");
endmodule

// File: test/prog_mem_model.sv
module prog_mem_model
(
	input  wire logic        clk,
	input  wire logic        prog_rd,
	input  wire logic [10:0] prog_addr,
	output logic      [15:0] prog_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] word;
	logic [15:0] last_ff;

	// ==========================================
	// Program store seen by the table unit
	assign word = {prog_addr[10:3] ^ 8'h3c, prog_addr[7:0] ^ 8'ha5};
	// Outside a read the bus shows the inverse of the last word, so a late sample fails
	assign prog_rdata = prog_rd ? word : ~last_ff;

	initial last_ff = 16'h0000;
	always @(posedge clk)
		if (prog_rd)
			last_ff <= word;
endmodule

// File: test/tb_table_mem_core.sv
module tb_table_mem_core
	import table_mem_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, reset_n, ms_n, sd_in, sck, dreq, dwr, dind, treq, tlast;
	logic [7:0]  daddr, dwd, tdest, rdata, tdest_o, tlow, latch, bank, lo, hi;
	logic [10:0] pc, faddr, paddr, exp_a;
	logic [15:0] prdata, w;
	logic        rvalid, restart, prd, stall, halt, done, sdo, sdoe, owned;
	logic [31:0] seed;
	int          mismatches, comparisons;

	table_mem_core dut (.clk(clk), .reset_n(reset_n), .prog_mode_select_n(ms_n),
		.prog_serial_data_in(sd_in), .prog_serial_clock(sck), .data_req(dreq), .data_write(dwr),
		.data_indirect(dind), .data_addr(daddr), .data_wdata(dwd), .table_req(treq),
		.table_last_page(tlast), .table_dest(tdest), .cur_pc(pc), .prog_rdata(prdata),
		.data_rdata_ff(rdata), .data_rvalid_ff(rvalid), .fetch_addr_ff(faddr),
		.fetch_restart_ff(restart), .prog_addr_ff(paddr), .prog_rd_ff(prd), .core_stall_ff(stall),
		.core_halt_ff(halt), .table_done_ff(done), .table_dest_ff(tdest_o), .table_low_ff(tlow),
		.table_high_latch_ff(latch), .bank_pointer_ff(bank), .prog_serial_data_out_ff(sdo),
		.prog_serial_data_oe_ff(sdoe), .prog_pins_owned_ff(owned));

	prog_mem_model pmem (.clk(clk), .prog_rd(prd), .prog_addr(paddr), .prog_rdata(prdata));

	always #2 clk = ~clk;

	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] word_at(logic [10:0] a);
		return {a[10:3] ^ 8'h3c, a[7:0] ^ 8'ha5};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ind);
		@(posedge clk);
		#1 dreq = 1'b1; dwr = 1'b1; dind = ind; daddr = a; dwd = d;
		@(posedge clk);
		#1 dreq = 1'b0; dwr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic ind, input logic [7:0] exp);
		@(posedge clk);
		#1 dreq = 1'b1; dind = ind; daddr = a;
		@(posedge clk);
		#1 dreq = 1'b0;
		@(posedge clk);
		#1 chk(rvalid, 1'b1);
		chk(rdata, exp);
	endtask

	// Request is held over the busy edge too, which must be refused
	// The latch is read back after the bench's own table read and a bus write to it that must be dropped
	task automatic table_rd(input logic last);
		w = word_at(exp_a);
		@(posedge clk);
		#1 treq = 1'b1;
		tlast = last;
		tdest = 8'(rnd());
		@(posedge clk);
		#1 chk({prd, stall, done}, 3'b110);
		chk(paddr, exp_a);
		@(posedge clk);
		#1 treq = 1'b0;
		chk({done, stall, prd}, 3'b110);
		chk({tlow, tdest_o}, {w[7:0], tdest});
		chk(latch, w[15:8]);
		@(posedge clk);
		#1 chk({done, stall, prd}, 3'b000);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	initial
	begin
		clk = 0; reset_n = 0; ms_n = 1; sd_in = 0; sck = 0; dreq = 0; dwr = 0; dind = 0;
		daddr = 0; dwd = 0; treq = 0; tlast = 0; tdest = 0; pc = 0;
		seed = 32'h55d25be5; mismatches = 0; comparisons = 0;
		repeat (8) @(posedge clk);
		#1 reset_n = 1;
		chk(faddr, 11'h000);
		@(posedge clk);
		#1 chk(restart, 0);
		chk(bank, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			lo = 8'h80 | 8'(rnd());
			hi = 8'(rnd());
			wr(lo, hi, 0);
			rd(lo, 0, hi);
		end
		rd(8'h28, 0, 8'h00);
		wr(8'h28, 8'hff, 0);
		rd(8'h28, 0, 8'h00);
		wr(8'h04, 8'h01, 0);
		chk(bank, 8'h01);
		wr(8'h85, 8'h77, 0);
		rd(8'h85, 0, 8'h77);
		rd(8'h85, 1, 8'h00);
		wr(8'h40, 8'h5a, 1);
		rd(8'h40, 1, 8'h5a);
		rd(8'h04, 1, 8'h01);
		rd(8'h40, 0, 8'h00);
		@(posedge clk);
		#1 reset_n = 1'b0;
		@(posedge clk);
		#1 reset_n = 1'b1;
		chk({restart, faddr, bank}, {1'b1, 11'h000, 8'h00});
		@(posedge clk);
		#1 chk(restart, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			lo = 8'(rnd());
			hi = 8'(rnd());
			pc = 11'(rnd());
			wr(8'h07, lo, 0);
			wr(8'h09, hi, 0);
			exp_a = i[0] ? {pc[10:8], lo} : {hi[2:0], lo};
			table_rd(i[0]);
		end
		wr(8'h08, ~w[15:8], 0);
		rd(8'h08, 0, w[15:8]);
		wr(8'h80, 8'hc3, 0);
		@(posedge clk);
		#1 ms_n = 0;
		repeat (4) @(posedge clk) #1 sck = ~sck;
		chk({halt, owned, sdoe, sdo}, 4'b1100);
		wr(8'h80, 8'h11, 0);
		@(posedge clk);
		#1 ms_n = 1;
		repeat (2) @(posedge clk);
		#1 chk({halt, owned}, 2'b00);
		rd(8'h80, 0, 8'hc3);
		test_done();
	end

	initial
	begin
		#100000;
		mismatches++;
		test_done();
	end
endmodule
